// ==== pkg/ecpsr_pkg.sv ====
`default_nettype none
package ecpsr_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ENG_N = 3;
  localparam int unsigned PC_W = 7;
  localparam logic [7:0] ENGINE1_START_POINTER_ADDR = 8'h37;
  localparam logic [7:0] ENGINE2_START_POINTER_ADDR = 8'h38;
  localparam logic [7:0] ENGINE3_START_POINTER_ADDR = 8'h39;
  localparam logic [7:0] STATUS_AND_ALERT_ADDR = 8'h3a;
  localparam logic [6:0] PC_RESET = 7'h00;
  localparam logic [6:0] PC_MAX = 7'h5f;
  // ----------------------------------------------------------------
  // status_and_alert fields
  // ----------------------------------------------------------------
  localparam int unsigned LED_DONE_BIT = 7;
  localparam int unsigned MASK_BUSY_BIT = 6;
  localparam int unsigned STARTUP_BUSY_BIT = 5;
  localparam int unsigned ENGINE_BUSY_BIT = 4;
  localparam int unsigned EXT_CLK_BIT = 3;
  localparam logic MASK_BUSY_RESET = 1'b1;
  localparam logic LED_DONE_RESET = 1'b0;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam real CLK_MHZ = 20.0;
  localparam real LED_CONV_MS = 2.7;
  localparam int unsigned LED_CONV_CYCLES =
    int'(LED_CONV_MS * 1000.0 * CLK_MHZ);
  localparam int unsigned CLK_DET_WINDOW = 64;
  localparam int unsigned CONV_CNT_W = 17;
  localparam int unsigned DET_CNT_W = 8;
endpackage
`default_nettype wire

// ==== core/ecpsr_sync.sv ====
`default_nettype none
module ecpsr_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  // ----------------------------------------------------------------
  // two-flop synchroniser per bit
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] hold_ff;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (rst) begin
        meta_ff[i] <= 1'b0;
        hold_ff[i] <= 1'b0;
      end else begin
        meta_ff[i] <= async_in[i];
        hold_ff[i] <= meta_ff[i];
      end
    end
  end

  assign sync_out = hold_ff;
endmodule
`default_nettype wire

// ==== core/ecpsr_led_timer.sv ====
`default_nettype none
module ecpsr_led_timer #(
  parameter int unsigned CNT_W = 17,
  parameter int unsigned CYCLES = 54000
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  output var  logic busy_ff,
  output var  logic done_ff
);
  // ----------------------------------------------------------------
  // conversion duration counter
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cnt_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start) begin
        cnt_ff  <= CNT_W'(CYCLES - 1);
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        if (cnt_ff == '0) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - CNT_W'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== core/ecpsr_regs.sv ====
`default_nettype none
module ecpsr_regs
  import ecpsr_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = ecpsr_pkg::LED_CONV_CYCLES,
  parameter int unsigned DET_WINDOW  = ecpsr_pkg::CLK_DET_WINDOW
) (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic [ecpsr_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [ecpsr_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output var  logic [ecpsr_pkg::DATA_W-1:0] reg_rdata_ff,
  input  wire logic                         chip_en,
  input  wire logic                         startup_running,
  input  wire logic [ecpsr_pkg::ENG_N-1:0]  engine_clearing,
  input  wire logic [ecpsr_pkg::ENG_N-1:0]  engine_end_event,
  input  wire logic                         clock_detect_enable,
  input  wire logic                         ext_clk_pin,
  output var  logic [ecpsr_pkg::PC_W-1:0]   engine1_start_field,
  output var  logic [ecpsr_pkg::PC_W-1:0]   engine2_start_field,
  output var  logic [ecpsr_pkg::PC_W-1:0]   engine3_start_field,
  output var  logic                         led_check_start_ff,
  output var  logic                         led_check_complete,
  output var  logic                         outside_clock_seen,
  output var  logic                         int_pin_out_ff,
  output var  logic                         int_pin_oe_ff
);
  import ecpsr_pkg::*;

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  logic                  status_sel;
  logic                  status_wr;
  logic                  status_rd;
  logic [ENG_N-1:0]      pc_sel;
  logic [ENG_N-1:0][7:0] pc_addr;

  assign pc_addr[0] = ENGINE1_START_POINTER_ADDR;
  assign pc_addr[1] = ENGINE2_START_POINTER_ADDR;
  assign pc_addr[2] = ENGINE3_START_POINTER_ADDR;
  assign status_sel = (reg_addr == STATUS_AND_ALERT_ADDR);
  assign status_wr  = reg_wr & status_sel;
  assign status_rd  = reg_rd & status_sel;

  // ----------------------------------------------------------------
  // engine start pointers
  // ----------------------------------------------------------------
  logic [ENG_N-1:0][PC_W-1:0] pc_ff;

  for (genvar e = 0; e < ENG_N; e++) begin : g_pc
    assign pc_sel[e] = (reg_addr == pc_addr[e]);
    always_ff @(posedge clk) begin
      if (rst) begin
        pc_ff[e] <= PC_RESET;
      end else if (reg_wr && pc_sel[e] &&
                   reg_wdata[PC_W-1:0] <= PC_MAX) begin
        pc_ff[e] <= reg_wdata[PC_W-1:0];
      end
    end
  end

  assign engine1_start_field = pc_ff[0];
  assign engine2_start_field = pc_ff[1];
  assign engine3_start_field = pc_ff[2];

  // ----------------------------------------------------------------
  // busy interrupt mask
  // ----------------------------------------------------------------
  logic mask_busy_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_busy_ff <= MASK_BUSY_RESET;
    end else if (status_wr) begin
      mask_busy_ff <= reg_wdata[MASK_BUSY_BIT];
    end
  end

  // ----------------------------------------------------------------
  // LED check conversion
  // ----------------------------------------------------------------
  logic conv_done;
  logic led_done_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      led_check_start_ff <= 1'b0;
    end else begin
      led_check_start_ff <= status_wr;
    end
  end

  ecpsr_led_timer #(
    .CNT_W  (CONV_CNT_W),
    .CYCLES (CONV_CYCLES)
  ) i_ecpsr_led_timer (
    .clk     (clk),
    .rst     (rst),
    .start   (led_check_start_ff),
    .busy_ff (),
    .done_ff (conv_done)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      led_done_ff <= LED_DONE_RESET;
    end else if (conv_done) begin
      led_done_ff <= 1'b1;
    end else if (status_wr) begin
      led_done_ff <= 1'b0;
    end
  end

  assign led_check_complete = led_done_ff;

  // ----------------------------------------------------------------
  // live busy status
  // ----------------------------------------------------------------
  logic startup_busy_ff;
  logic engine_busy_ff;
  logic startup_prev_ff;
  logic engine_prev_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      startup_busy_ff <= 1'b1;
      engine_busy_ff  <= 1'b0;
    end else begin
      startup_busy_ff <= startup_running | ~chip_en;
      engine_busy_ff  <= |engine_clearing;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      startup_prev_ff <= 1'b1;
      engine_prev_ff  <= 1'b0;
    end else begin
      startup_prev_ff <= startup_busy_ff;
      engine_prev_ff  <= engine_busy_ff;
    end
  end

  // ----------------------------------------------------------------
  // busy-end alert
  // ----------------------------------------------------------------
  logic busy_fall;
  logic busy_alert_ff;

  assign busy_fall = (startup_prev_ff & ~startup_busy_ff) |
                     (engine_prev_ff & ~engine_busy_ff);

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_alert_ff <= 1'b0;
    end else if (busy_fall && !mask_busy_ff) begin
      busy_alert_ff <= 1'b1;
    end else if (status_rd || mask_busy_ff) begin
      busy_alert_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // engine alert flags
  // ----------------------------------------------------------------
  logic [ENG_N-1:0] eng_alert_ff;

  for (genvar e = 0; e < ENG_N; e++) begin : g_alert
    always_ff @(posedge clk) begin
      if (rst) begin
        eng_alert_ff[e] <= 1'b0;
      end else if (engine_end_event[e]) begin
        eng_alert_ff[e] <= 1'b1;
      end else if (status_rd) begin
        eng_alert_ff[e] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // external clock detection
  // ----------------------------------------------------------------
  logic                 ext_clk_sync;
  logic                 ext_clk_prev_ff;
  logic                 ext_edge;
  logic [DET_CNT_W-1:0] det_cnt_ff;
  logic                 ext_seen_ff;

  ecpsr_sync #(
    .WIDTH (1)
  ) i_ecpsr_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (ext_clk_pin),
    .sync_out (ext_clk_sync)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      ext_clk_prev_ff <= 1'b0;
    end else begin
      ext_clk_prev_ff <= ext_clk_sync;
    end
  end

  assign ext_edge = ext_clk_sync & ~ext_clk_prev_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      det_cnt_ff  <= '0;
      ext_seen_ff <= 1'b0;
    end else if (!clock_detect_enable) begin
      det_cnt_ff  <= '0;
      ext_seen_ff <= 1'b0;
    end else if (ext_edge) begin
      det_cnt_ff  <= DET_CNT_W'(DET_WINDOW - 1);
      ext_seen_ff <= 1'b1;
    end else if (det_cnt_ff != '0) begin
      det_cnt_ff <= det_cnt_ff - DET_CNT_W'(1);
    end else begin
      ext_seen_ff <= 1'b0;
    end
  end

  assign outside_clock_seen = ext_seen_ff;

  // ----------------------------------------------------------------
  // interrupt pin
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      int_pin_out_ff <= 1'b0;
      int_pin_oe_ff  <= 1'b0;
    end else begin
      int_pin_out_ff <= 1'b0;
      int_pin_oe_ff  <= busy_alert_ff | (|eng_alert_ff);
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] nxt_rdata;

  always_comb begin
    status_word = '0;
    status_word[LED_DONE_BIT]     = led_done_ff;
    status_word[MASK_BUSY_BIT]    = mask_busy_ff;
    status_word[STARTUP_BUSY_BIT] = startup_busy_ff;
    status_word[ENGINE_BUSY_BIT]  = engine_busy_ff;
    status_word[EXT_CLK_BIT]      = ext_seen_ff;
    status_word[ENG_N-1:0]        = {eng_alert_ff[0], eng_alert_ff[1],
                                     eng_alert_ff[2]};
  end

  always_comb begin
    nxt_rdata = '0;
    if (status_sel) begin
      nxt_rdata = status_word;
    end else if (pc_sel[0]) begin
      nxt_rdata = {1'b0, pc_ff[0]};
    end else if (pc_sel[1]) begin
      nxt_rdata = {1'b0, pc_ff[1]};
    end else if (pc_sel[2]) begin
      nxt_rdata = {1'b0, pc_ff[2]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata_ff <= '0;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

endmodule
`default_nettype wire

// ==== dv/ecpsr_regs_checker.sv ====
`default_nettype none
module ecpsr_regs_checker
  import ecpsr_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = ecpsr_pkg::LED_CONV_CYCLES,
  parameter int unsigned DET_WINDOW  = ecpsr_pkg::CLK_DET_WINDOW
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic       chip_en,
  input wire logic       startup_running,
  input wire logic [2:0] engine_clearing,
  input wire logic [2:0] engine_end_event,
  input wire logic       clock_detect_enable,
  input wire logic       ext_clk_pin,
  input wire logic [6:0] engine1_start_field,
  input wire logic [6:0] engine2_start_field,
  input wire logic [6:0] engine3_start_field,
  input wire logic       led_check_start_ff,
  input wire logic       led_check_complete,
  input wire logic       outside_clock_seen,
  input wire logic       int_pin_out_ff,
  input wire logic       int_pin_oe_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // port relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic st_wr;
  logic p1_wr;
  assign st_wr = reg_wr && (reg_addr == STATUS_AND_ALERT_ADDR);
  assign p1_wr = reg_wr && (reg_addr == ENGINE1_START_POINTER_ADDR);
  a_status_wr_start: assert property (
    st_wr |=> led_check_start_ff) else $error("no start after write");
  a_start_has_cause: assert property (
    led_check_start_ff |-> $past(st_wr)) else $error("stray start pulse");
  a_done_sticky: assert property (
    led_check_complete && !st_wr |=> led_check_complete)
    else $error("done flag dropped");
  a_ptr_limit: assert property (
    engine1_start_field <= PC_MAX && engine2_start_field <= PC_MAX
    && engine3_start_field <= PC_MAX) else $error("pointer too big");
  a_ptr_write: assert property (
    p1_wr && reg_wdata[6:0] <= PC_MAX |=>
    engine1_start_field == $past(reg_wdata[6:0])) else $error("ptr write");
  a_ptr_keep: assert property (
    p1_wr && reg_wdata[6:0] > PC_MAX |=> $stable(engine1_start_field))
    else $error("bad pointer taken");
  a_ptr_read: assert property (
    reg_rd && reg_addr == ENGINE1_START_POINTER_ADDR |=>
    reg_rdata_ff == {1'b0, $past(engine1_start_field)}) else $error("ptr rd");
  a_engine_alert: assert property (
    engine_end_event != 3'h0 |-> ##2 int_pin_oe_ff) else $error("no alert");
  a_pin_low: assert property (
    int_pin_oe_ff |-> !int_pin_out_ff) else $error("pin driven high");
  a_reset_state: assert property (
    $fell(rst) |-> engine1_start_field == PC_RESET && !int_pin_oe_ff
    && engine3_start_field == PC_RESET) else $error("reset state");
endmodule
bind ecpsr_regs ecpsr_regs_checker #(
  .CONV_CYCLES(CONV_CYCLES), .DET_WINDOW(DET_WINDOW)
) i_ecpsr_regs_checker (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata_ff, .chip_en, .startup_running, .engine_clearing,
  .engine_end_event, .clock_detect_enable, .ext_clk_pin,
  .engine1_start_field, .engine2_start_field, .engine3_start_field,
  .led_check_start_ff, .led_check_complete, .outside_clock_seen,
  .int_pin_out_ff, .int_pin_oe_ff);
`default_nettype wire

// ==== dv/ecpsr_clk_src.sv ====
`default_nettype none
module ecpsr_clk_src (
  input  wire logic clk,
  input  wire logic run,
  output var  logic ext_clk_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // outside clock, held at ground when stopped
  // ----------------------------------------------------------------
  logic [1:0] div_ff = 2'h0;
  initial ext_clk_pin = 1'b0;
  always @(posedge clk) begin
    div_ff <= run ? div_ff + 2'h1 : 2'h0;
    ext_clk_pin <= run && div_ff[1];
  end
endmodule
`default_nettype wire

// ==== dv/tb_ecpsr_regs.sv ====
`default_nettype none
module tb_ecpsr_regs
  import ecpsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned CONV = 20;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       chip_en = 1'b1;
  logic       startup_running = 1'b0;
  logic [2:0] engine_clearing = 3'h0;
  logic [2:0] engine_end_event = 3'h0;
  logic       clock_detect_enable = 1'b0;
  logic       clk_run = 1'b0;
  wire        ext_clk_pin;
  wire  [7:0] reg_rdata_ff;
  wire  [6:0] engine1_start_field;
  wire  [6:0] engine2_start_field;
  wire  [6:0] engine3_start_field;
  wire        led_check_start_ff;
  wire        led_check_complete;
  wire        outside_clock_seen;
  wire        int_pin_out_ff;
  wire        int_pin_oe_ff;
  int         n_mismatch = 0;
  int         tests_run = 0;
  int         cyc = 0;
  int         n;
  // ----------------------------------------------------------------
  // clock, parts and access tasks
  // ----------------------------------------------------------------
  always #25 clk = ~clk;
  ecpsr_clk_src i_ecpsr_clk_src (.clk(clk), .run(clk_run),
    .ext_clk_pin(ext_clk_pin));
  ecpsr_regs #(.CONV_CYCLES(CONV), .DET_WINDOW(64)) i_ecpsr_regs (.clk,
    .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff, .chip_en,
    .startup_running, .engine_clearing, .engine_end_event,
    .clock_detect_enable, .ext_clk_pin, .engine1_start_field,
    .engine2_start_field, .engine3_start_field, .led_check_start_ff,
    .led_check_complete, .outside_clock_seen, .int_pin_out_ff,
    .int_pin_oe_ff);
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk8(input string s, input logic [7:0] e,
                      input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk8($sformatf("reg %h", a), e, reg_rdata_ff);
  endtask
  task automatic oe(input logic e);
    chk8("int oe", {7'h00, e}, {7'h00, int_pin_oe_ff});
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // tests; pointers stay in range and keep their value on an out-of-range write
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    tick(3);
    for (int i = 0; i < 3; i++) rd(8'h37 + 8'(i), 8'h00);
    rd(8'h3a, 8'h40);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      wr(8'h37 + 8'(i), 8'h5f);
      wr(8'h37 + 8'(i), 8'h60);
      rd(8'h37 + 8'(i), 8'h5f);
    end
    rd(8'h3b, 8'h00);
    chk8("eng1 field", 8'h5f, {1'b0, engine1_start_field});
    chk8("eng2 field", 8'h5f, {1'b0, engine2_start_field});
    chk8("eng3 field", 8'h5f, {1'b0, engine3_start_field});
    $display("test pointers done");
    @(posedge clk) startup_running <= 1'b1;
    tick(3);
    rd(8'h3a, 8'h60);
    @(posedge clk) startup_running <= 1'b0;
    tick(4);
    oe(1'b0);
    rd(8'h3a, 8'h40);
    @(posedge clk) chip_en <= 1'b0;
    tick(3);
    rd(8'h3a, 8'h60);
    @(posedge clk) chip_en <= 1'b1;
    tick(4);
    $display("test busy masked done");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) engine_end_event <= 3'h1 << i;
      @(posedge clk) engine_end_event <= 3'h0;
      tick(2);
      oe(1'b1);
      rd(8'h3a, 8'h40 | (8'h04 >> i));
      tick(2);
      oe(1'b0);
      rd(8'h3a, 8'h40);
    end
    $display("test engine alerts done");
    wr(8'h3a, 8'h00);
    n = 0;
    while (led_check_complete !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    chk8("conv cycles", 8'(CONV + 2), 8'(n));
    tick(30);
    rd(8'h3a, 8'h80);
    @(posedge clk) engine_clearing <= 3'h2;
    tick(3);
    oe(1'b0);
    rd(8'h3a, 8'h90);
    @(posedge clk) engine_clearing <= 3'h0;
    tick(4);
    oe(1'b1);
    rd(8'h3a, 8'h80);
    tick(2);
    oe(1'b0);
    @(posedge clk) startup_running <= 1'b1;
    tick(3);
    rd(8'h3a, 8'ha0);
    @(posedge clk) startup_running <= 1'b0;
    tick(4);
    oe(1'b1);
    rd(8'h3a, 8'h80);
    tick(2);
    oe(1'b0);
    wr(8'h3a, 8'h40);
    tick(1);
    chk8("led done", 8'h00, {7'h00, led_check_complete});
    $display("test led and busy done");
    @(posedge clk) clk_run <= 1'b1;
    tick(100);
    rd(8'h3a, 8'hc0);
    chk8("clock seen", 8'h00, {7'h00, outside_clock_seen});
    @(posedge clk) clock_detect_enable <= 1'b1;
    tick(100);
    rd(8'h3a, 8'hc8);
    chk8("clock seen", 8'h01, {7'h00, outside_clock_seen});
    @(posedge clk) clk_run <= 1'b0;
    tick(100);
    rd(8'h3a, 8'hc0);
    chk8("clock seen", 8'h00, {7'h00, outside_clock_seen});
    $display("test clock detect done");
    final_report();
  end
endmodule
`default_nettype wire
